// ===== logic/pcg_clock_gating.v
// Peripheral clock gating controller with Avalon-MM register slave
//
// Implementation choice: the Avalon-MM slave port.
`timescale 1ns/100ps
`include "pcg_regs.vh"

module pcg_clock_gating (
  input wire CLK,
  input wire RST,
  input wire [11:0] AVS_ADDRESS,
  input wire AVS_READ,
  input wire AVS_WRITE,
  input wire [31:0] AVS_WRITEDATA,
  input wire [3:0] AVS_BYTEENABLE,
  output reg [31:0] AVS_READDATA,
  output wire AVS_WAITREQUEST,
  output reg [1:0] AVS_RESPONSE,
  input wire [1:0] PWR_STATE,
  input wire [7:0] PERIPH_SEL,
  input wire PERIPH_ACCESS,
  output wire PERIPH_FAULT,
  output reg [7:0] UNIT_CLK_EN,
  output reg [1:0] CONVERTER_RATE_LIMIT,
  output wire IRQ
);

  // ==========================================================================
  // Registers
  reg [31:0] run_g0_r;
  reg [31:0] run_g1_r;
  reg [31:0] slp_g0_r;
  reg [31:0] slp_g1_r;
  reg [31:0] dsl_g0_r;
  reg [31:0] dsl_g1_r;
  reg [31:0] cfg_r;
  reg [31:0] stat_r;
  reg [31:0] mask_r;
  reg done_r;
  reg [1:0] pwr_s1_r;
  reg [1:0] pwr_r;
  reg [31:0] g0_sel;
  reg [31:0] g1_sel;
  reg [31:0] rdata_nxt;
  reg hit;
  reg [31:0] wmask;
  reg [7:0] en_nxt;
  wire [31:0] be_mask;
  wire req;
  wire wr_take;
  wire fault_ev;
  wire [31:0] stat_nxt;

  assign be_mask = {{8{AVS_BYTEENABLE[3]}}, {8{AVS_BYTEENABLE[2]}},
                    {8{AVS_BYTEENABLE[1]}}, {8{AVS_BYTEENABLE[0]}}};
  assign req = AVS_READ | AVS_WRITE;
  // One wait cycle per access; answer on the second edge
  assign AVS_WAITREQUEST = req & ~done_r;
  assign wr_take = AVS_WRITE & done_r;

  // ==========================================================================
  // Power state synchroniser
  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      pwr_s1_r <= `PCG_PWR_RUN;
      pwr_r <= `PCG_PWR_RUN;
    end else begin
      pwr_s1_r <= PWR_STATE;
      pwr_r <= pwr_s1_r;
    end
  end

  // ==========================================================================
  // Gating set selection
  always @* begin
    g0_sel = run_g0_r;
    g1_sel = run_g1_r;
    if (cfg_r[`PCG_BIT_AUTO]) begin
      if (pwr_r == `PCG_PWR_SLEEP) begin
        g0_sel = slp_g0_r;
        g1_sel = slp_g1_r;
      end else if (pwr_r == `PCG_PWR_DEEP) begin
        g0_sel = dsl_g0_r;
        g1_sel = dsl_g1_r;
      end
    end
  end

  // Unit order: converter, watchdog, timers 0..2, two-wire, sync serial, async pair folded
  always @* begin
    en_nxt[0] = g0_sel[`PCG_BIT_ADC];
    en_nxt[1] = g0_sel[`PCG_BIT_WDOG];
    en_nxt[2] = g1_sel[`PCG_BIT_TMR0];
    en_nxt[3] = g1_sel[`PCG_BIT_TMR1];
    en_nxt[4] = g1_sel[`PCG_BIT_TMR2];
    en_nxt[5] = g1_sel[`PCG_BIT_TWS];
    en_nxt[6] = g1_sel[`PCG_BIT_SYNS];
    en_nxt[7] = g1_sel[`PCG_BIT_ASY0] | g1_sel[`PCG_BIT_ASY1];
  end

  // Registered enables avoid glitches on the unit clock gates
  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      UNIT_CLK_EN <= 8'h00;
      CONVERTER_RATE_LIMIT <= 2'h0;
    end else begin
      UNIT_CLK_EN <= en_nxt;
      // Deep-sleep has no rate field; keep the run limit then
      if (cfg_r[`PCG_BIT_AUTO] && pwr_r == `PCG_PWR_DEEP) begin
        CONVERTER_RATE_LIMIT <= run_g0_r[`PCG_RATE_LO+1:`PCG_RATE_LO];
      end else begin
        CONVERTER_RATE_LIMIT <= g0_sel[`PCG_RATE_LO+1:`PCG_RATE_LO];
      end
    end
  end

  // Access to a unit with its clock stopped is faulted
  assign PERIPH_FAULT = PERIPH_ACCESS & ~|(PERIPH_SEL & UNIT_CLK_EN);
  assign fault_ev = PERIPH_FAULT;

  // ==========================================================================
  // Address decode
  always @* begin
    hit = 1'b1;
    rdata_nxt = 32'h0000_0000;
    wmask = 32'h0000_0000;
    if (AVS_ADDRESS == `PCG_OFS_RUN_G0) begin
      rdata_nxt = run_g0_r;
      wmask = `PCG_MASK_G0_RS;
    end else if (AVS_ADDRESS == `PCG_OFS_RUN_G1) begin
      rdata_nxt = run_g1_r;
      wmask = `PCG_MASK_G1;
    end else if (AVS_ADDRESS == `PCG_OFS_SLP_G0) begin
      rdata_nxt = slp_g0_r;
      wmask = `PCG_MASK_G0_RS;
    end else if (AVS_ADDRESS == `PCG_OFS_SLP_G1) begin
      rdata_nxt = slp_g1_r;
      wmask = `PCG_MASK_G1;
    end else if (AVS_ADDRESS == `PCG_OFS_DSL_G0) begin
      rdata_nxt = dsl_g0_r;
      wmask = `PCG_MASK_G0_DS;
    end else if (AVS_ADDRESS == `PCG_OFS_DSL_G1) begin
      rdata_nxt = dsl_g1_r;
      wmask = `PCG_MASK_G1;
    end else if (AVS_ADDRESS == `PCG_OFS_RUN_CFG) begin
      rdata_nxt = cfg_r;
      wmask = `PCG_MASK_CFG;
    end else if (AVS_ADDRESS == `PCG_OFS_IRQ_STAT) begin
      rdata_nxt = stat_r;
    end else if (AVS_ADDRESS == `PCG_OFS_IRQ_MASK) begin
      rdata_nxt = mask_r;
      wmask = `PCG_MASK_IRQ;
    end else begin
      hit = 1'b0;
    end
    wmask = wmask & be_mask;
  end

  // Write-one-to-clear status; a new event wins over the clear
  assign stat_nxt = (stat_r & ~((wr_take && hit && AVS_ADDRESS == `PCG_OFS_IRQ_STAT) ?
                    (AVS_WRITEDATA & be_mask) : 32'h0000_0000))
                    | ({31'h0, fault_ev} << `PCG_IRQ_FAULT)
                    | ({31'h0, req & done_r & ~hit} << `PCG_IRQ_UNMAPPED);

  // ==========================================================================
  // Register writes and bus answer
  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      run_g0_r <= `PCG_RESET_VAL;
      run_g1_r <= `PCG_RESET_VAL;
      slp_g0_r <= `PCG_RESET_VAL;
      slp_g1_r <= `PCG_RESET_VAL;
      dsl_g0_r <= `PCG_RESET_VAL;
      dsl_g1_r <= `PCG_RESET_VAL;
      cfg_r <= `PCG_RESET_VAL;
      stat_r <= `PCG_RESET_VAL;
      mask_r <= `PCG_RESET_VAL;
      done_r <= 1'b0;
      AVS_READDATA <= 32'h0000_0000;
      AVS_RESPONSE <= 2'h0;
    end else begin
      done_r <= req & ~done_r;
      stat_r <= stat_nxt & `PCG_MASK_IRQ;
      if (req & ~done_r) begin
        AVS_READDATA <= AVS_READ ? rdata_nxt : 32'h0000_0000;
        AVS_RESPONSE <= hit ? 2'h0 : 2'h3;
      end
      if (wr_take && hit) begin
        if (AVS_ADDRESS == `PCG_OFS_RUN_G0) run_g0_r <= (run_g0_r & ~wmask) | (AVS_WRITEDATA & wmask);
        if (AVS_ADDRESS == `PCG_OFS_RUN_G1) run_g1_r <= (run_g1_r & ~wmask) | (AVS_WRITEDATA & wmask);
        if (AVS_ADDRESS == `PCG_OFS_SLP_G0) slp_g0_r <= (slp_g0_r & ~wmask) | (AVS_WRITEDATA & wmask);
        if (AVS_ADDRESS == `PCG_OFS_SLP_G1) slp_g1_r <= (slp_g1_r & ~wmask) | (AVS_WRITEDATA & wmask);
        if (AVS_ADDRESS == `PCG_OFS_DSL_G0) dsl_g0_r <= (dsl_g0_r & ~wmask) | (AVS_WRITEDATA & wmask);
        if (AVS_ADDRESS == `PCG_OFS_DSL_G1) dsl_g1_r <= (dsl_g1_r & ~wmask) | (AVS_WRITEDATA & wmask);
        if (AVS_ADDRESS == `PCG_OFS_RUN_CFG) cfg_r <= (cfg_r & ~wmask) | (AVS_WRITEDATA & wmask);
        if (AVS_ADDRESS == `PCG_OFS_IRQ_MASK) mask_r <= (mask_r & ~wmask) | (AVS_WRITEDATA & wmask);
      end
    end
  end

  assign IRQ = |(stat_r & mask_r);

endmodule

// ===== logic/pcg_regs.vh
// Register offsets, field positions and reset values of the peripheral clock gating block
// Contract
// - Each gating bit drives one peripheral unit clock enable: set runs the unit, clear stops it; here the two async serial bits are ORed into one enable.
// - An access to a unit whose clock is gated off ends with a bus fault instead of completing.
// - After reset every gating bit is zero so all units start unclocked.
// - Each group has run, sleep and deep-sleep gating sets, and the one matching the power state applies.
// - Sleep and deep-sleep sets apply only while the auto clock gate select bit is set, else the run set governs.
// - Bit 16 of each group-0 gating register enables the converter module clock, read/write, reset zero.
// - Bit 3 of each group-0 gating register enables the watchdog clock, read/write, reset zero.
// - Reserved bits read as zero and ignore writes, and software writes back what it read.
// - In group-1 registers bit 12 gates two-wire serial, bit 4 sync serial, bits 1 and 0 the async serials.
`ifndef PCG_REGS_VH
`define PCG_REGS_VH

// ==========================================================================
// Byte offsets
`define PCG_OFS_RUN_G0 12'h100
`define PCG_OFS_RUN_G1 12'h104
`define PCG_OFS_SLP_G0 12'h110
`define PCG_OFS_SLP_G1 12'h114
`define PCG_OFS_DSL_G0 12'h120
`define PCG_OFS_DSL_G1 12'h124
`define PCG_OFS_RUN_CFG 12'h060
`define PCG_OFS_IRQ_STAT 12'h130
`define PCG_OFS_IRQ_MASK 12'h134

// ==========================================================================
// Writable-bit masks and field positions
`define PCG_MASK_G0_RS 32'h0001_0308
`define PCG_MASK_G0_DS 32'h0001_0008
`define PCG_MASK_G1 32'h0007_1013
`define PCG_MASK_CFG 32'h0000_0001
`define PCG_MASK_IRQ 32'h0000_0003
`define PCG_BIT_ADC 16
`define PCG_BIT_WDOG 3
`define PCG_BIT_TMR0 16
`define PCG_BIT_TMR1 17
`define PCG_BIT_TMR2 18
`define PCG_BIT_TWS 12
`define PCG_BIT_SYNS 4
`define PCG_BIT_ASY1 1
`define PCG_BIT_ASY0 0
`define PCG_RATE_LO 8
`define PCG_BIT_AUTO 0
`define PCG_IRQ_FAULT 0
`define PCG_IRQ_UNMAPPED 1
`define PCG_RESET_VAL 32'h0000_0000

// ==========================================================================
// Power states
`define PCG_PWR_RUN 2'h0
`define PCG_PWR_SLEEP 2'h1
`define PCG_PWR_DEEP 2'h2

`endif

// ===== dv/pcg_dv_map.svh
// Writable-bit mask of each register, zero where nothing is mapped
`ifndef PCG_DV_MAP_SVH
`define PCG_DV_MAP_SVH
`include "pcg_regs.vh"
function automatic logic [31:0] pcg_msk(input logic [11:0] a);
  case (a)
    `PCG_OFS_RUN_G0, `PCG_OFS_SLP_G0: pcg_msk = `PCG_MASK_G0_RS;
    `PCG_OFS_DSL_G0: pcg_msk = `PCG_MASK_G0_DS;
    `PCG_OFS_RUN_G1, `PCG_OFS_SLP_G1, `PCG_OFS_DSL_G1: pcg_msk = `PCG_MASK_G1;
    `PCG_OFS_RUN_CFG: pcg_msk = `PCG_MASK_CFG;
    `PCG_OFS_IRQ_STAT, `PCG_OFS_IRQ_MASK: pcg_msk = `PCG_MASK_IRQ;
    default: pcg_msk = 32'h0;
  endcase
endfunction
`endif

// ===== dv/pcg_unit_model.sv
// Peripheral-side source of one-cycle unit accesses
`timescale 1ns/100ps
module pcg_unit_model (
  input logic clk, rst, go,
  input logic [2:0] unit,
  output logic [7:0] sel,
  output logic access
);
  // Idle select keeps moving so a stale unit is never trusted
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      access <= 1'b0;
      sel <= 8'h00;
    end else begin
      access <= go;
      sel <= go ? 8'h01 << unit : sel + 8'h5B;
    end
  end
endmodule

// ===== dv/pcg_props.sv
// Port assertions of the clock gating block
`timescale 1ns/100ps
`include "pcg_dv_map.svh"
module pcg_props (
  input logic CLK, RST, AVS_READ, AVS_WRITE, AVS_WAITREQUEST, PERIPH_ACCESS, PERIPH_FAULT, IRQ,
  input logic [11:0] AVS_ADDRESS,
  input logic [31:0] AVS_READDATA,
  input logic [1:0] AVS_RESPONSE, PWR_STATE, CONVERTER_RATE_LIMIT,
  input logic [7:0] PERIPH_SEL, UNIT_CLK_EN
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  sequence s_rd; AVS_READ && AVS_WAITREQUEST; endsequence
  sequence s_done; AVS_READ && !AVS_WAITREQUEST ##1 !(AVS_READ || AVS_WRITE); endsequence
  sequence s_quiet; (!AVS_WRITE && $stable(PWR_STATE)) [*5]; endsequence
  chk_wait_once: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=>
    !AVS_WAITREQUEST) else $error("long wait");
  chk_read_ok: assert property (s_rd ##0 pcg_msk(AVS_ADDRESS) != 32'h0 |=>
    AVS_RESPONSE == 2'h0) else $error("bad response");
  chk_unmapped_resp: assert property (s_rd ##0 pcg_msk(AVS_ADDRESS) == 32'h0 |=>
    AVS_RESPONSE == 2'h3 && AVS_READDATA == 32'h0) else $error("unmapped read");
  chk_resv_zero: assert property (s_rd |=>
    (AVS_READDATA & ~pcg_msk($past(AVS_ADDRESS))) == 32'h0) else $error("reserved set");
  chk_fault_gated: assert property (PERIPH_FAULT ==
    (PERIPH_ACCESS && |(PERIPH_SEL & ~UNIT_CLK_EN))) else $error("fault wrong");
  chk_reset_zero: assert property ($fell(RST) |-> UNIT_CLK_EN == 8'h00 &&
    CONVERTER_RATE_LIMIT == 2'h0 && !IRQ) else $error("reset value");
  chk_en_quiet: assert property (s_quiet |-> $stable(UNIT_CLK_EN) &&
    $stable(CONVERTER_RATE_LIMIT)) else $error("enable moved");
  chk_rd_stand: assert property (s_done |-> $stable(AVS_READDATA)) else $error("data moved");
endmodule
bind pcg_clock_gating pcg_props u_props (.CLK, .RST, .AVS_READ, .AVS_WRITE, .AVS_WAITREQUEST,
  .PERIPH_ACCESS, .PERIPH_FAULT, .IRQ, .AVS_ADDRESS, .AVS_READDATA, .AVS_RESPONSE,
  .PWR_STATE, .CONVERTER_RATE_LIMIT, .PERIPH_SEL, .UNIT_CLK_EN);

// ===== dv/tb.sv
// Self-checking bench of the clock gating block
`timescale 1ns/100ps
`include "pcg_dv_map.svh"
module tb;
  logic CLK = 1'b0, RST = 1'b1, rd = 1'b0, wr = 1'b0, go = 1'b0, wq, wq_n, acc, flt, irq;
  logic [11:0] adr = 12'h000;
  logic [31:0] wd = 32'h0, rdat, s = 32'h3E, q, sh [0:5];
  logic [1:0] pwr = 2'h0, rsp, r, rate;
  logic [7:0] sel, en, exp;
  logic [2:0] unit = 3'h0;
  logic [11:0] ofs [0:8] = '{`PCG_OFS_RUN_G0, `PCG_OFS_RUN_G1, `PCG_OFS_SLP_G0,
    `PCG_OFS_SLP_G1, `PCG_OFS_DSL_G0, `PCG_OFS_DSL_G1, `PCG_OFS_RUN_CFG,
    `PCG_OFS_IRQ_STAT, `PCG_OFS_IRQ_MASK};
  int fails = 0, compares = 0;
  pcg_clock_gating u_dut (.CLK, .RST, .AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr),
    .AVS_WRITEDATA(wd), .AVS_BYTEENABLE(4'hF), .AVS_READDATA(rdat), .AVS_WAITREQUEST(wq),
    .AVS_RESPONSE(rsp), .PWR_STATE(pwr), .PERIPH_SEL(sel), .PERIPH_ACCESS(acc),
    .PERIPH_FAULT(flt), .UNIT_CLK_EN(en), .CONVERTER_RATE_LIMIT(rate), .IRQ(irq));
  pcg_unit_model u_unit (.clk(CLK), .rst(RST), .go, .unit, .sel, .access(acc));
  initial forever #2.5 CLK = ~CLK;
  // Settled value of waitrequest for the coming edge
  always @(negedge CLK) wq_n <= wq;
  function automatic logic [31:0] rnd();
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction
  function automatic logic [7:0] en_of(input logic [31:0] g0, g1);
    return {g1[1] | g1[0], g1[4], g1[12], g1[18], g1[17], g1[16], g0[3], g0[16]};
  endfunction
  task chk(input logic [31:0] g, e);
    compares++;
    if (g !== e) begin
      fails++;
      $display("Error t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge CLK);
    adr <= a;
    wd <= d;
    wr <= w;
    rd <= !w;
    do begin
      @(posedge CLK);
      n++;
    end while (wq_n !== 1'b0 && n < 40);
    q = rdat;
    r = rsp;
    if (n >= 40) fails++;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task wt(input int n);
    repeat (n) @(posedge CLK);
    @(negedge CLK);
  endtask
  task poke(input logic [2:0] u);
    @(posedge CLK);
    go <= 1'b1;
    unit <= u;
    @(posedge CLK);
    go <= 1'b0;
    @(negedge CLK);
    chk(flt, !exp[u]);
  endtask
  task end_sim();
    $display("fails=%0d compares=%0d", fails, compares);
    if (fails == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #200000;
    fails++;
    end_sim();
  end
  initial begin
    repeat (12) @(posedge CLK);
    RST <= 1'b0;
    foreach (ofs[i]) begin
      bus(0, ofs[i], 0);
      chk(q, 0);
    end
    repeat (3) for (int i = 0; i < 6; i++) begin
      sh[i] = rnd();
      bus(1, ofs[i], sh[i]);
      bus(0, ofs[i], 0);
      sh[i] &= pcg_msk(ofs[i]);
      chk(q, sh[i]);
    end
    for (int a = 0; a < 2; a++) begin
      bus(1, `PCG_OFS_RUN_CFG, a);
      for (int p = 0; p < 4; p++) begin
        int j;
        pwr <= p[1:0];
        j = (a == 1 && (p == 1 || p == 2)) ? 2 * p : 0;
        wt(4);
        chk(en, en_of(sh[j], sh[j + 1]));
        chk(rate, j == 2 ? sh[2][9:8] : sh[0][9:8]);
      end
    end
    for (int v = 0; v < 3; v++) begin
      sh[0] = 32'h0001_0000 | (v << 8);
      bus(1, `PCG_OFS_RUN_G0, sh[0]);
      wt(2);
      chk(rate, v);
    end
    exp = en_of(sh[0], sh[1]);
    chk(en, exp);
    bus(1, `PCG_OFS_IRQ_STAT, 32'h3);
    bus(1, `PCG_OFS_IRQ_MASK, 32'h0);
    for (int u = 0; u < 8; u++) poke(u[2:0]);
    bus(0, 12'h200, 0);
    chk(r, 2'h3);
    bus(0, `PCG_OFS_IRQ_STAT, 0);
    chk(q, 32'h3);
    chk(irq, 0);
    bus(1, `PCG_OFS_IRQ_MASK, 32'h1);
    wt(2);
    chk(irq, 1);
    bus(1, `PCG_OFS_IRQ_STAT, 32'h1);
    wt(2);
    chk(irq, 0);
    end_sim();
  end
endmodule
